// ---- src/umi_regs.vh ----
// Purpose: Register offsets, field positions, reset values and codes
// Assumes: APB word access, registers in the low byte of each word
// Notes:   Shared by the interrupt logic top and its encoder
`ifndef UMI_REGS_VH
`define UMI_REGS_VH

// ----------------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------------
`define UMI_OFF_IER      8'h04
`define UMI_OFF_IIR      8'h08
`define UMI_OFF_FCR      8'h0C
`define UMI_OFF_MCR      8'h10
`define UMI_OFF_EFR      8'h14
`define UMI_OFF_MSR      8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UMI_IER_CTS      7
`define UMI_IER_RTS      6
`define UMI_IER_XOFF     5
`define UMI_IER_SLEEP    4
`define UMI_IER_LSR      2
`define UMI_IER_THR      1
`define UMI_IER_RHR      0
`define UMI_EFR_ENH      4
`define UMI_FCR_EN       0
`define UMI_MCR_LOOP     4
`define UMI_MCR_RTS      1
`define UMI_MSR_CTS      4
`define UMI_MSR_DCTS     0

// ----------------------------------------------------------------------
// Write masks
// ----------------------------------------------------------------------
`define UMI_IER_BASE_MSK 8'h07
`define UMI_IER_ENH_MSK  8'hF0
`define UMI_FCR_BASE_MSK 8'hCF
`define UMI_FCR_ENH_MSK  8'h30
`define UMI_MCR_BASE_MSK 8'h12
`define UMI_MCR_ENH_MSK  8'hE4
`define UMI_EFR_MSK      8'hFF

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define UMI_RST_IER      8'h00
`define UMI_RST_FCR      8'h00
`define UMI_RST_MCR      8'h00
`define UMI_RST_EFR      8'h00

// ----------------------------------------------------------------------
// Identification codes (bits 5:0) and pending vector positions
// ----------------------------------------------------------------------
`define UMI_ID_LSR       6'h06
`define UMI_ID_RXTO      6'h0C
`define UMI_ID_RHR       6'h04
`define UMI_ID_THR       6'h02
`define UMI_ID_MODEM     6'h00
`define UMI_ID_XOFF      6'h10
`define UMI_ID_FLOW      6'h20
`define UMI_ID_NONE      6'h01
`define UMI_P_LSR        0
`define UMI_P_RXTO       1
`define UMI_P_RHR        2
`define UMI_P_THR        3
`define UMI_P_MODEM      4
`define UMI_P_XOFF       5
`define UMI_P_FLOW       6
`define UMI_P_W          7

`endif

// ---- src/umi_edge_det.v ----
// Purpose: Remembers a line's previous level and flags its edges
// Assumes: Line is synchronous to pclk
// Notes:   Reset value of the history is the line's idle level
`timescale 1ns/1ps
module umi_edge_det #(
  parameter RST_VAL = 1'b1
) (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  // Line
  input  wire level,
  // Edges
  output wire rise,
  output wire fall
);

  reg prev_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= RST_VAL;
    end else begin
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;

endmodule // umi_edge_det

// ---- src/umi_prio_enc.v ----
// Purpose: Picks the highest-priority enabled source and encodes it
// Assumes: Pending bits are already gated by their enables
// Notes:   Output carries bits 5:0 of the identification register
`timescale 1ns/1ps
`include "umi_regs.vh"
module umi_prio_enc (
  // Enabled pending sources
  input  wire [`UMI_P_W-1:0] pend,
  // Encoded source, bit 0 low while pending
  output reg  [5:0]          ident
);

  always @* begin
    ident = `UMI_ID_NONE;
    if (pend[`UMI_P_LSR]) begin
      ident = `UMI_ID_LSR;
    end else if (pend[`UMI_P_RXTO]) begin
      ident = `UMI_ID_RXTO;
    end else if (pend[`UMI_P_RHR]) begin
      ident = `UMI_ID_RHR;
    end else if (pend[`UMI_P_THR]) begin
      ident = `UMI_ID_THR;
    end else if (pend[`UMI_P_MODEM]) begin
      ident = `UMI_ID_MODEM;
    end else if (pend[`UMI_P_XOFF]) begin
      ident = `UMI_ID_XOFF;
    end else if (pend[`UMI_P_FLOW]) begin
      ident = `UMI_ID_FLOW;
    end
  end

endmodule // umi_prio_enc

// ---- src/umi_top.v ----
// Purpose: Modem status, interrupt enable and identification logic
// Assumes: All inputs synchronous to pclk; APB slave, no wait states
// Notes:   Datapath sources arrive as levels or one-cycle pulses
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "umi_regs.vh"
module umi_top (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Modem lines, active low
  input  wire        cts_n_pin,
  input  wire        rts_n_line,
  // Sources from the UART datapath
  input  wire        lsr_err,
  input  wire        rx_timeout,
  input  wire        rx_trig,
  input  wire        tx_space_ok,
  input  wire        tx_write,
  input  wire        xoff_evt,
  // Block outputs
  output wire        irq,
  output wire        sleep_req,
  output wire        fifo_en
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function [7:0] wmerge;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] wmsk;
    begin
      wmerge = (old_val & ~wmsk) | (new_val & wmsk);
    end
  endfunction

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  reg  [7:0]          ier_q;
  reg  [7:0]          fcr_q;
  reg  [7:0]          mcr_q;
  reg  [7:0]          efr_q;
  reg                 dcts_q;
  reg                 dcts_seen_q;
  reg                 thr_pend_q;
  reg                 xoff_pend_q;
  reg                 cts_flow_q;
  reg                 rts_flow_q;
  reg  [5:0]          id_seen_q;
  reg                 irq_q;
  reg                 sleep_q;
  reg                 fifo_en_q;
  reg  [31:0]         prdata_q;
  reg                 pready_q;
  reg                 pslverr_q;

  reg  [7:0]          ier_d;
  reg  [7:0]          fcr_d;
  reg  [7:0]          mcr_d;
  reg  [7:0]          efr_d;
  reg                 dcts_d;
  reg                 thr_pend_d;
  reg                 xoff_pend_d;
  reg                 cts_flow_d;
  reg                 rts_flow_d;

  reg                 sel_ier;
  reg                 sel_iir;
  reg                 sel_fcr;
  reg                 sel_mcr;
  reg                 sel_efr;
  reg                 sel_msr;
  reg                 addr_hit;
  reg  [7:0]          rd_val;

  wire                apb_setup;
  wire                apb_acc;
  wire                wr_acc;
  wire                rd_acc;
  wire                enh_en;
  wire                cts_line_n;
  wire                cts_rise;
  wire                cts_fall;
  wire                rts_rise;
  wire                tx_rise;
  wire [7:0]          msr_val;
  wire [7:0]          iir_val;
  wire [`UMI_P_W-1:0] pend;
  wire [5:0]          ident;
  wire                iir_clr;

  // --------------------------------------------------------------------
  // APB phases
  // --------------------------------------------------------------------
  assign apb_setup = psel & ~penable;
  assign apb_acc   = psel & penable & pready_q;
  assign wr_acc    = apb_acc & pwrite;
  assign rd_acc    = apb_acc & ~pwrite;
  assign enh_en    = efr_q[`UMI_EFR_ENH];

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  always @* begin
    sel_ier  = 1'b0;
    sel_iir  = 1'b0;
    sel_fcr  = 1'b0;
    sel_mcr  = 1'b0;
    sel_efr  = 1'b0;
    sel_msr  = 1'b0;
    addr_hit = 1'b1;
    rd_val   = 8'h00;
    if (paddr == `UMI_OFF_IER) begin
      sel_ier = 1'b1;
      rd_val  = ier_q;
    end else if (paddr == `UMI_OFF_IIR) begin
      sel_iir = 1'b1;
      rd_val  = iir_val;
    end else if (paddr == `UMI_OFF_FCR) begin
      sel_fcr = 1'b1;
      rd_val  = fcr_q;
    end else if (paddr == `UMI_OFF_MCR) begin
      sel_mcr = 1'b1;
      rd_val  = mcr_q;
    end else if (paddr == `UMI_OFF_EFR) begin
      sel_efr = 1'b1;
      rd_val  = efr_q;
    end else if (paddr == `UMI_OFF_MSR) begin
      sel_msr = 1'b1;
      rd_val  = msr_val;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Modem line and transmit space edges
  // --------------------------------------------------------------------
  // In loopback the control bit drives the line as an active-low pin
  assign cts_line_n = mcr_q[`UMI_MCR_LOOP] ? ~mcr_q[`UMI_MCR_RTS] :
                      cts_n_pin;

  umi_edge_det #(.RST_VAL(1'b1)) u_cts_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (cts_line_n),
    .rise    (cts_rise),
    .fall    (cts_fall)
  );

  umi_edge_det #(.RST_VAL(1'b1)) u_rts_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (rts_n_line),
    .rise    (rts_rise),
    .fall    ()
  );

  // Transmit space crossing its threshold is the only thing that arms
  // the transmit interrupt, so enabling it never fires it by itself
  umi_edge_det #(.RST_VAL(1'b0)) u_tx_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (tx_space_ok),
    .rise    (tx_rise),
    .fall    ()
  );

  // --------------------------------------------------------------------
  // Status and identification values
  // --------------------------------------------------------------------
  assign msr_val = {3'b000, ~cts_line_n, 3'b000, dcts_q};

  assign pend[`UMI_P_LSR]   = lsr_err & ier_q[`UMI_IER_LSR];
  assign pend[`UMI_P_RXTO]  = rx_timeout & ier_q[`UMI_IER_RHR];
  assign pend[`UMI_P_RHR]   = rx_trig & ier_q[`UMI_IER_RHR];
  assign pend[`UMI_P_THR]   = thr_pend_q & ier_q[`UMI_IER_THR];
  assign pend[`UMI_P_MODEM] = dcts_q & ier_q[`UMI_IER_CTS];
  assign pend[`UMI_P_XOFF]  = xoff_pend_q & ier_q[`UMI_IER_XOFF];
  assign pend[`UMI_P_FLOW]  = (cts_flow_q & ier_q[`UMI_IER_CTS]) |
                              (rts_flow_q & ier_q[`UMI_IER_RTS]);

  umi_prio_enc u_prio (
    .pend  (pend),
    .ident (ident)
  );

  // Bit 0 of the code is the not-pending flag
  assign iir_val = {fcr_q[`UMI_FCR_EN], fcr_q[`UMI_FCR_EN],
                    ident};

  // Read side effects act only on what the read actually showed
  assign iir_clr = rd_acc & sel_iir;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always @* begin
    ier_d = ier_q;
    fcr_d = fcr_q;
    mcr_d = mcr_q;
    efr_d = efr_q;
    if (wr_acc && sel_ier) begin
      ier_d = wmerge(ier_q, pwdata[7:0], `UMI_IER_BASE_MSK |
                     (enh_en ? `UMI_IER_ENH_MSK : 8'h00));
    end
    if (wr_acc && sel_fcr) begin
      fcr_d = wmerge(fcr_q, pwdata[7:0], `UMI_FCR_BASE_MSK |
                     (enh_en ? `UMI_FCR_ENH_MSK : 8'h00));
    end
    if (wr_acc && sel_mcr) begin
      mcr_d = wmerge(mcr_q, pwdata[7:0], `UMI_MCR_BASE_MSK |
                     (enh_en ? `UMI_MCR_ENH_MSK : 8'h00));
    end
    if (wr_acc && sel_efr) begin
      efr_d = wmerge(efr_q, pwdata[7:0], `UMI_EFR_MSK);
    end

    // Set wins over the read clear
    dcts_d = (cts_rise | cts_fall) |
             (dcts_q & ~(rd_acc & sel_msr & dcts_seen_q));

    // Disabling drops a stale request so re-enabling starts clean
    thr_pend_d = (tx_rise & ier_q[`UMI_IER_THR]) |
                 (thr_pend_q & ier_q[`UMI_IER_THR] & ~tx_write &
                  ~(iir_clr && id_seen_q == `UMI_ID_THR));

    xoff_pend_d = (xoff_evt & ier_q[`UMI_IER_XOFF]) |
                  (xoff_pend_q &
                   ~(iir_clr && id_seen_q == `UMI_ID_XOFF));

    cts_flow_d = (cts_rise & ier_q[`UMI_IER_CTS]) |
                 (cts_flow_q &
                  ~(iir_clr && id_seen_q == `UMI_ID_FLOW));
    rts_flow_d = (rts_rise & ier_q[`UMI_IER_RTS]) |
                 (rts_flow_q &
                  ~(iir_clr && id_seen_q == `UMI_ID_FLOW));
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ier_q       <= `UMI_RST_IER;
      fcr_q       <= `UMI_RST_FCR;
      mcr_q       <= `UMI_RST_MCR;
      efr_q       <= `UMI_RST_EFR;
      dcts_q      <= 1'b0;
      thr_pend_q  <= 1'b0;
      xoff_pend_q <= 1'b0;
      cts_flow_q  <= 1'b0;
      rts_flow_q  <= 1'b0;
      irq_q       <= 1'b0;
      sleep_q     <= 1'b0;
      fifo_en_q   <= 1'b0;
    end else begin
      ier_q       <= ier_d;
      fcr_q       <= fcr_d;
      mcr_q       <= mcr_d;
      efr_q       <= efr_d;
      dcts_q      <= dcts_d;
      thr_pend_q  <= thr_pend_d;
      xoff_pend_q <= xoff_pend_d;
      cts_flow_q  <= cts_flow_d;
      rts_flow_q  <= rts_flow_d;
      irq_q       <= |pend;
      sleep_q     <= ier_d[`UMI_IER_SLEEP];
      fifo_en_q   <= fcr_d[`UMI_FCR_EN];
    end
  end

  // --------------------------------------------------------------------
  // APB answer
  // --------------------------------------------------------------------
  // No wait states: data are captured in setup so outputs stay registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q    <= 32'h0000_0000;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
      dcts_seen_q <= 1'b0;
      id_seen_q   <= `UMI_ID_NONE;
    end else begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup & ~addr_hit;
      if (apb_setup) begin
        prdata_q    <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
        dcts_seen_q <= dcts_q;
        id_seen_q   <= ident;
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign irq       = irq_q;
  assign sleep_req = sleep_q;
  assign fifo_en   = fifo_en_q;

endmodule // umi_top

// ---- testbench/umi_modem_model.sv ----
// Purpose: Far-side modem driving the clear- and request-to-send lines
// Assumes: Bench asks for a line level, model moves it after an edge
// Notes:   Lines idle high (inactive) out of reset
`timescale 1ns/1ps
module umi_modem_model (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  // Requested line levels, active low
  input  wire cts_want_n,
  input  wire rts_want_n,
  // Lines into the block, active low
  output reg  cts_n_q,
  output reg  rts_n_q
);
  // Registered so a line never moves in the block's sampling step
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_n_q <= 1'b1;
      rts_n_q <= 1'b1;
    end else begin
      cts_n_q <= cts_want_n;
      rts_n_q <= rts_want_n;
    end
  end
endmodule // umi_modem_model

// ---- testbench/umi_top_properties.sv ----
// Purpose: Port-level properties of the interrupt logic
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to every instance of the top
`timescale 1ns/1ps
`include "umi_regs.vh"
module umi_top_properties (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Block outputs
  input wire        irq,
  input wire        sleep_req,
  input wire        fifo_en
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire mapped = paddr inside {8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  wire rd_id  = pready && !pwrite && paddr == `UMI_OFF_IIR;
  // Plain expression: a sequence cannot be the argument of $past
  wire wr_acc = psel && penable && pready && pwrite;
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  pready_wait_a: assert property (setup_s |=> access_s)
    else $error("pready missing after setup");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  slverr_decode_a: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match decode");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  ident_status_a: assert property (rd_id |-> prdata[0] == !irq)
    else $error("ident bit 0 disagrees with irq");
  ident_mirror_a: assert property (rd_id |-> prdata[7:6] == {2{fifo_en}})
    else $error("ident bits 7:6 differ from fifo enable");
  sleep_write_a: assert property ($changed(sleep_req) |->
    $past(wr_acc && paddr == `UMI_OFF_IER))
    else $error("sleep request moved without enable write");
  fifo_write_a: assert property ($changed(fifo_en) |->
    $past(wr_acc && paddr == `UMI_OFF_FCR))
    else $error("fifo enable moved without control write");
endmodule // umi_top_properties

bind umi_top umi_top_properties i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq), .sleep_req(sleep_req), .fifo_en(fifo_en)
);

// ---- testbench/uart_modem_status_interrupt_logic_tb.sv ----
// Purpose: Directed register-level tests of the interrupt logic
// Assumes: One APB request at a time, modem lines from the model
// Notes:   Identification reads clear the transmit, XOFF and flow source they show
`timescale 1ns/1ps
`include "umi_regs.vh"
module uart_modem_status_interrupt_logic_tb;
  localparam [7:0] a_en = `UMI_OFF_IER;
  localparam [7:0] a_id = `UMI_OFF_IIR;
  localparam [7:0] a_fc = `UMI_OFF_FCR;
  localparam [7:0] a_mc = `UMI_OFF_MCR;
  localparam [7:0] a_ef = `UMI_OFF_EFR;
  localparam [7:0] a_ms = `UMI_OFF_MSR;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [7:0]  paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg lsr_err = 0, rx_timeout = 0, rx_trig = 0, tx_space_ok = 0;
  reg tx_write = 0, xoff_evt = 0, cts_want_n = 1, rts_want_n = 1, err;
  wire [31:0] prdata;
  wire pready, pslverr, irq, sleep_req, fifo_en, cts_n_pin, rts_n_line;
  integer mismatches = 0, check_count = 0, cyc = 0;

  always #12.5 pclk = ~pclk;

  umi_modem_model i_umi_modem_model (.pclk(pclk), .presetn(presetn),
    .cts_want_n(cts_want_n), .rts_want_n(rts_want_n),
    .cts_n_q(cts_n_pin), .rts_n_q(rts_n_line));
  umi_top i_umi_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cts_n_pin(cts_n_pin), .rts_n_line(rts_n_line), .lsr_err(lsr_err),
    .rx_timeout(rx_timeout), .rx_trig(rx_trig), .tx_space_ok(tx_space_ok),
    .tx_write(tx_write), .xoff_evt(xoff_evt), .irq(irq),
    .sleep_req(sleep_req), .fifo_en(fifo_en));

  task summarize;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits on pready; only the bench ceiling ends a hung wait
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask

  task wt;
    repeat (3) @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches = mismatches + 1;
      summarize;
    end
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(a_en, 8'h00);
    rdc(a_id, 8'h01);
    rdc(a_ms, 8'h00);
    chk({sleep_req, fifo_en, irq}, 32'h0);
    apb(1'b1, a_en, 8'hFF);
    rdc(a_en, 8'h07);
    apb(1'b1, a_ef, 8'h10);
    apb(1'b1, a_en, 8'hFF);
    rdc(a_en, 8'hF7);
    chk(sleep_req, 32'h1);
    apb(1'b1, a_fc, 8'h01);
    rdc(a_id, 8'hC1);
    apb(1'b1, a_en, 8'h03);
    lsr_err <= 1'b1;
    rx_timeout <= 1'b1;
    rx_trig <= 1'b1;
    wt;
    rdc(a_id, 8'hCC);
    apb(1'b1, a_en, 8'h07);
    wt;
    rdc(a_id, 8'hC6);
    chk(irq, 32'h1);
    lsr_err <= 1'b0;
    wt;
    rdc(a_id, 8'hCC);
    rx_timeout <= 1'b0;
    wt;
    rdc(a_id, 8'hC4);
    rx_trig <= 1'b0;
    tx_space_ok <= 1'b1;
    wt;
    rdc(a_id, 8'hC2);
    rdc(a_id, 8'hC1);
    chk(irq, 32'h0);
    tx_space_ok <= 1'b0;
    apb(1'b1, a_en, 8'h05);
    apb(1'b1, a_en, 8'h07);
    wt;
    chk(irq, 32'h0);
    tx_space_ok <= 1'b1;
    wt;
    chk(irq, 32'h1);
    tx_write <= 1'b1;
    @(posedge pclk);
    tx_write <= 1'b0;
    wt;
    chk(irq, 32'h0);
    apb(1'b1, a_en, 8'h80);
    cts_want_n <= 1'b0;
    wt;
    rdc(a_id, 8'hC0);
    rdc(a_ms, 8'h11);
    rdc(a_ms, 8'h10);
    rdc(a_id, 8'hC1);
    cts_want_n <= 1'b1;
    wt;
    rdc(a_ms, 8'h01);
    rdc(a_id, 8'hE0);
    rdc(a_id, 8'hC1);
    apb(1'b1, a_en, 8'h40);
    rts_want_n <= 1'b0;
    wt;
    rdc(a_id, 8'hC1);
    rts_want_n <= 1'b1;
    wt;
    rdc(a_id, 8'hE0);
    apb(1'b1, a_en, 8'h20);
    xoff_evt <= 1'b1;
    @(posedge pclk);
    xoff_evt <= 1'b0;
    wt;
    rdc(a_id, 8'hD0);
    apb(1'b1, a_id, 8'hFF);
    rdc(a_id, 8'hC1);
    apb(1'b1, a_mc, 8'h12);
    wt;
    apb(1'b0, a_ms, 8'h00);
    chk(rd & 32'h10, 32'h10);
    apb(1'b0, 8'h3C, 8'h00);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    summarize;
  end
endmodule // uart_modem_status_interrupt_logic_tb
